//--- core/wvx_map.vh
`ifndef WVX_MAP_VH
`define WVX_MAP_VH
// Register byte addresses
`define WVX_CTRL_ADDR 8'h00
`define WVX_FDMASK_ADDR 8'h08
`define WVX_FDCTRL_ADDR 8'h0C
`define WVX_STATUS_ADDR 8'h10
`define WVX_DTBOTH_ADDR 8'h18
`define WVX_LOW_SIDE_DEAD_TIME_ADDR 8'h20
`define WVX_HIGH_SIDE_DEAD_TIME_ADDR 8'h24
`define WVX_OOE_ADDR 8'h28
`define WVX_PORTOV_ADDR 8'h2C
`define WVX_LOCK_ADDR 8'h30
// CTRL fields
`define WVX_CTRL_PGM 5
`define WVX_CTRL_CWCM 4
// FDCTRL fields
`define WVX_FD_DBD 4
`define WVX_FD_MODE 2
// STATUS fields
`define WVX_ST_FDF 2
`define WVX_ST_HSBV 1
`define WVX_ST_LSBV 0
// Fault action codes
`define WVX_ACT_NONE 2'h0
`define WVX_ACT_CLRDIR 2'h3
`define WVX_RESET_BYTE 8'h00
`endif

//--- core/wvx_waveform_extension.v
// Notes on behaviour
// - With any dead-time channel on, each compare waveform splits into low and high side.
// - Dead-time outputs replace normal port values under port override control.
// - Pattern mode bypasses dead-time insertion entirely.
// - Channel dead-time enable hands pin pair to override enable bits.
// - Off interval with both sides low; sides never switch together.
// - Four generators share double buffered low and high dead-time values.
// - Eight-bit dead-time counter decrements each clock, stops at zero.
// - Counter above one forces both sides of the channel off.
// - Rising edge loads low-side value; falling edge loads high-side value.
// - Pattern mode reuses dead-time storage as pattern across the port.
// - Pattern mode drives compare A onto pins with override enable set.
// - Buffered pattern and override values copy to active only on update.
// - Each event channel maskable as fault input; enabled ones are ORed.
// - Direction-clear action on fault clears port direction bits.
// - Fault sets fault flag and timer error flag.
// - Fault action within two clocks, independent of processor.
// - Latched restore: wait fault gone and flag cleared, then update.
// - Cycle-by-cycle restore: wait fault gone, then next update.
// - Leaving fault restores directions of enabled dead-time channels.
// - Fault leaves port override register intact but blocks its writes.
// - Lock bit blocks writes to control, override enable, fault mask.
// - Action code 00 disables protection; 11 clears enabled channel dirs.
// - Restart select clear is latched, set is cycle-by-cycle.
// - Writing one clears fault flag; writing zero leaves it.
// - Debug break is a fault source unless ignore-debug-break is set.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "wvx_map.vh"
module wvx_waveform_extension #(
  parameter CH = 4,
  parameter EVW = 8
) (
  input wire ref_clk,
  input wire srst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [CH-1:0] waveform_generator_output,
  input wire update,
  input wire [EVW-1:0] fault_events,
  input wire debug_break,
  input wire [7:0] port_dir,
  output reg [7:0] pin_out,
  output reg [7:0] pin_override,
  output reg [7:0] dir_clear_mask,
  output reg fault_active,
  output reg timer_error_flag
);
  reg [7:0] ctrl_reg;
  reg [EVW-1:0] fmask_reg;
  reg [7:0] fdctrl_reg;
  reg fdf_reg;
  reg [7:0] low_side_dead_time_reg;
  reg [7:0] high_side_dead_time_reg;
  reg [7:0] low_side_dead_time_buf_reg;
  reg [7:0] high_side_dead_time_buf_reg;
  reg lsbv_reg;
  reg hsbv_reg;
  reg [7:0] ooe_reg;
  reg [7:0] ooe_buf_reg;
  reg [7:0] portov_reg;
  reg lock_reg;
  reg aw_done_reg;
  reg w_done_reg;
  reg [31:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [CH-1:0] wg_prev_reg;
  reg [7:0] cnt_reg [0:CH-1];
  reg [CH-1:0] ls_reg;
  reg [CH-1:0] hs_reg;
  reg fault_hold_reg;
  reg [31:0] rdata_next;
  reg [1:0] rresp_next;
  reg [7:0] out_next;
  reg [7:0] ov_next;
  integer i;

  wire any_en = ctrl_reg[`WVX_CTRL_PGM] | (|ctrl_reg[CH-1:0]);
  wire pattern_mode_enable = ctrl_reg[`WVX_CTRL_PGM];
  wire [1:0] fact = fdctrl_reg[1:0];
  wire prot_on = (fact == `WVX_ACT_CLRDIR);
  wire dbg_fault = debug_break & ~fdctrl_reg[`WVX_FD_DBD];
  wire fault_cond = prot_on & ((|(fault_events & fmask_reg)) | dbg_fault);
  wire wr_go = aw_done_reg & w_done_reg & ~s_axi_bvalid;
  wire [7:0] waddr = awaddr_reg[7:0];
  wire [7:0] wbyte = wdata_reg[7:0];
  wire wb0 = wstrb_reg[0];
  wire [7:0] dt_ch_mask = {ctrl_reg[3], ctrl_reg[3], ctrl_reg[2],
    ctrl_reg[2], ctrl_reg[1], ctrl_reg[1], ctrl_reg[0],
    ctrl_reg[0]};
  wire fault_state = fault_hold_reg | fault_cond;

  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = is_addr(a, `WVX_CTRL_ADDR) ||
        is_addr(a, `WVX_FDMASK_ADDR) || is_addr(a, `WVX_FDCTRL_ADDR) ||
        is_addr(a, `WVX_STATUS_ADDR) || is_addr(a, `WVX_DTBOTH_ADDR) ||
        is_addr(a, `WVX_LOW_SIDE_DEAD_TIME_ADDR) || is_addr(a, `WVX_HIGH_SIDE_DEAD_TIME_ADDR) ||
        is_addr(a, `WVX_OOE_ADDR) || is_addr(a, `WVX_PORTOV_ADDR) ||
        is_addr(a, `WVX_LOCK_ADDR);
    end
  endfunction

  assign s_axi_awready = ~aw_done_reg;
  assign s_axi_wready = ~w_done_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge ref_clk) begin
    if (srst) begin
      aw_done_reg <= 1'b0;
      w_done_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_done_reg) begin
        aw_done_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_done_reg) begin
        w_done_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (!is_mapped(waddr) || awaddr_reg[31:8] != 24'h000000)
          ? 2'h2 : 2'h0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_done_reg <= 1'b0;
        w_done_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = 2'h0;
    if (is_addr(s_axi_araddr[7:0], `WVX_CTRL_ADDR))
      rdata_next[7:0] = ctrl_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_FDMASK_ADDR))
      rdata_next[EVW-1:0] = fmask_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_FDCTRL_ADDR))
      rdata_next[7:0] = fdctrl_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_STATUS_ADDR))
      rdata_next[7:0] = {5'h00, fdf_reg, hsbv_reg, lsbv_reg};
    else if (is_addr(s_axi_araddr[7:0], `WVX_LOW_SIDE_DEAD_TIME_ADDR))
      rdata_next[7:0] = low_side_dead_time_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_HIGH_SIDE_DEAD_TIME_ADDR))
      rdata_next[7:0] = high_side_dead_time_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_OOE_ADDR))
      rdata_next[7:0] = ooe_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_PORTOV_ADDR))
      rdata_next[7:0] = portov_reg;
    else if (is_addr(s_axi_araddr[7:0], `WVX_LOCK_ADDR))
      rdata_next[7:0] = {7'h00, lock_reg};
    else if (is_addr(s_axi_araddr[7:0], `WVX_DTBOTH_ADDR))
      rdata_next[7:0] = low_side_dead_time_buf_reg;
    else
      rresp_next = 2'h2;
    if (s_axi_araddr[31:8] != 24'h000000)
      rresp_next = 2'h2;
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Register writes, buffers and fault flag
  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg <= `WVX_RESET_BYTE;
      fmask_reg <= {EVW{1'b0}};
      fdctrl_reg <= `WVX_RESET_BYTE;
      fdf_reg <= 1'b0;
      low_side_dead_time_reg <= `WVX_RESET_BYTE;
      high_side_dead_time_reg <= `WVX_RESET_BYTE;
      low_side_dead_time_buf_reg <= `WVX_RESET_BYTE;
      high_side_dead_time_buf_reg <= `WVX_RESET_BYTE;
      lsbv_reg <= 1'b0;
      hsbv_reg <= 1'b0;
      ooe_reg <= `WVX_RESET_BYTE;
      ooe_buf_reg <= `WVX_RESET_BYTE;
      portov_reg <= `WVX_RESET_BYTE;
      lock_reg <= 1'b0;
    end else begin
      if (update) begin
        if (lsbv_reg)
          low_side_dead_time_reg <= low_side_dead_time_buf_reg;
        if (hsbv_reg)
          high_side_dead_time_reg <= high_side_dead_time_buf_reg;
        ooe_reg <= ooe_buf_reg;
        lsbv_reg <= 1'b0;
        hsbv_reg <= 1'b0;
      end
      if (wr_go && wb0) begin
        if (is_addr(waddr, `WVX_CTRL_ADDR) && !lock_reg)
          ctrl_reg <= {2'b00, wbyte[5:0]};
        else if (is_addr(waddr, `WVX_FDMASK_ADDR) && !lock_reg)
          fmask_reg <= wdata_reg[EVW-1:0];
        else if (is_addr(waddr, `WVX_FDCTRL_ADDR))
          fdctrl_reg <= {3'b000, wbyte[4], 1'b0, wbyte[2:0]};
        else if (is_addr(waddr, `WVX_OOE_ADDR) && !lock_reg)
          ooe_buf_reg <= wbyte;
        else if (is_addr(waddr, `WVX_PORTOV_ADDR) && !fault_state)
          portov_reg <= wbyte;
        else if (is_addr(waddr, `WVX_LOCK_ADDR))
          lock_reg <= lock_reg | wbyte[0];
        else if (is_addr(waddr, `WVX_LOW_SIDE_DEAD_TIME_ADDR)) begin
          low_side_dead_time_buf_reg <= wbyte;
          lsbv_reg <= 1'b1;
        end else if (is_addr(waddr, `WVX_HIGH_SIDE_DEAD_TIME_ADDR)) begin
          high_side_dead_time_buf_reg <= wbyte;
          hsbv_reg <= 1'b1;
        end else if (is_addr(waddr, `WVX_DTBOTH_ADDR)) begin
          low_side_dead_time_buf_reg <= wbyte;
          high_side_dead_time_buf_reg <= wbyte;
          lsbv_reg <= 1'b1;
          hsbv_reg <= 1'b1;
        end
      end
      // Set wins over write-one clear
      if (fault_cond)
        fdf_reg <= 1'b1;
      else if (wr_go && wb0 && is_addr(waddr, `WVX_STATUS_ADDR) &&
               wbyte[`WVX_ST_FDF])
        fdf_reg <= 1'b0;
    end
  end

  // Fault state hold and release on update
  always @(posedge ref_clk) begin
    if (srst) begin
      fault_hold_reg <= 1'b0;
      timer_error_flag <= 1'b0;
    end else begin
      timer_error_flag <= fault_cond;
      if (fault_cond)
        fault_hold_reg <= 1'b1;
      else if (fault_hold_reg && update) begin
        if (fdctrl_reg[`WVX_FD_MODE])
          fault_hold_reg <= 1'b0;
        else if (!fdf_reg)
          fault_hold_reg <= 1'b0;
      end
    end
  end

  // Dead-time generators
  genvar g;
  generate
    for (g = 0; g < CH; g = g + 1) begin : dtg
      wire wg = ctrl_reg[`WVX_CTRL_CWCM] ? waveform_generator_output[0]
                                         : waveform_generator_output[g];
      always @(posedge ref_clk) begin
        if (srst) begin
          wg_prev_reg[g] <= 1'b0;
          cnt_reg[g] <= 8'h00;
          ls_reg[g] <= 1'b0;
          hs_reg[g] <= 1'b0;
        end else begin
          wg_prev_reg[g] <= wg;
          if (wg && !wg_prev_reg[g])
            cnt_reg[g] <= low_side_dead_time_reg;
          else if (!wg && wg_prev_reg[g])
            cnt_reg[g] <= high_side_dead_time_reg;
          else if (cnt_reg[g] != 8'h00)
            cnt_reg[g] <= cnt_reg[g] - 8'h01;
          if (wg != wg_prev_reg[g] || cnt_reg[g] > 8'h01) begin
            ls_reg[g] <= 1'b0;
            hs_reg[g] <= 1'b0;
          end else begin
            ls_reg[g] <= wg_prev_reg[g];
            hs_reg[g] <= ~wg_prev_reg[g];
          end
        end
      end
    end
  endgenerate

  // Port override mux
  always @* begin
    out_next = 8'h00;
    ov_next = 8'h00;
    if (pattern_mode_enable) begin
      for (i = 0; i < 8; i = i + 1) begin
        ov_next[i] = ooe_reg[i];
        out_next[i] = waveform_generator_output[0] | high_side_dead_time_reg[i];
      end
    end else if (any_en) begin
      for (i = 0; i < CH; i = i + 1) begin
        out_next[2*i] = ls_reg[i];
        out_next[2*i+1] = hs_reg[i];
        ov_next[2*i] = ctrl_reg[i] & ooe_reg[2*i];
        ov_next[2*i+1] = ctrl_reg[i] & ooe_reg[2*i+1];
      end
    end
    ov_next = ov_next & portov_reg;
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pin_out <= 8'h00;
      pin_override <= 8'h00;
      dir_clear_mask <= 8'h00;
      fault_active <= 1'b0;
    end else begin
      pin_out <= out_next;
      pin_override <= ov_next;
      fault_active <= fault_state;
      // Direction clear; port restores when mask drops
      dir_clear_mask <= fault_state ? (dt_ch_mask & port_dir) : 8'h00;
    end
  end
endmodule // wvx_waveform_extension

//--- sim/wvx_waveform_extension_chk.sv
`timescale 1ns/1ps
module wvx_chk #(
  parameter CH = 4,
  parameter EVW = 8
) (
  input wire ref_clk,
  input wire srst,
  input wire update,
  input wire [EVW-1:0] fault_events,
  input wire debug_break,
  input wire [7:0] pin_override,
  input wire [7:0] dir_clear_mask,
  input wire fault_active,
  input wire timer_error_flag
);
  wire src = |fault_events || debug_break;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  fault_cause_a: assert property ($rose(fault_active) |->
    $past(src) || $past(src, 2)) else $error("fault without source");
  fault_exit_a: assert property ($fell(fault_active) |->
    $past(update) || $past(update, 2)) else $error("exit off update");
  error_flag_a: assert property ($rose(fault_active) |->
    ##[0:1] (timer_error_flag || $past(timer_error_flag)))
    else $error("error flag missing");
  flag_fault_a: assert property (timer_error_flag |->
    ##[0:1] fault_active) else $error("flag without fault");
  clear_in_fault_a: assert property (|dir_clear_mask |->
    fault_active || $past(fault_active)) else $error("stray clear");
  clear_pairs_a: assert property (dir_clear_mask[0] == dir_clear_mask[1] &&
    dir_clear_mask[2] == dir_clear_mask[3] &&
    dir_clear_mask[4] == dir_clear_mask[5] &&
    dir_clear_mask[6] == dir_clear_mask[7]) else $error("split pair");
  exit_restore_a: assert property ($fell(fault_active) |->
    ##[0:1] dir_clear_mask == 8'h00) else $error("dirs not restored");
  override_kept_a: assert property ($rose(fault_active) |->
    $stable(pin_override)) else $error("override changed");
  cover property ($rose(fault_active));
  cover property ($fell(fault_active));
  cover property (|dir_clear_mask);
endmodule // wvx_chk

bind wvx_waveform_extension wvx_chk #(.CH(CH), .EVW(EVW)) chk (
  .ref_clk(ref_clk), .srst(srst), .update(update),
  .fault_events(fault_events), .debug_break(debug_break),
  .pin_override(pin_override), .dir_clear_mask(dir_clear_mask),
  .fault_active(fault_active), .timer_error_flag(timer_error_flag));

//--- sim/wvx_tc_model.sv
`timescale 1ns/1ps
module wvx_tc_model #(
  parameter PER = 64
) (
  ref_clk,
  srst,
  run,
  kick,
  wave,
  upd
);
  input wire ref_clk;
  input wire srst;
  input wire run;
  input wire kick;
  output reg [3:0] wave;
  output wire upd;
  reg [7:0] cnt_reg;
  assign upd = (run && cnt_reg == PER - 1) || kick;
  // Compare levels 32, 16, 8 and 4
  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= 8'h00;
      wave <= 4'h0;
    end else if (run) begin
      cnt_reg <= (cnt_reg == PER - 1) ? 8'h00 : cnt_reg + 8'h01;
      wave <= {cnt_reg < 8'h04, cnt_reg < 8'h08, cnt_reg < 8'h10,
        cnt_reg < 8'h20};
    end
  end
endmodule // wvx_tc_model

//--- sim/test_waveform_dead_time_fault_extension.sv
`timescale 1ns/1ps
module test_waveform_dead_time_fault_extension;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, debug_break = 1'b0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [7:0] fault_events = 8'h00, port_dir = 8'hFF;
  reg run = 1'b0, kick = 1'b0, lk = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] waveform_generator_output;
  wire [7:0] pin_out, pin_override, dir_clear_mask;
  wire update, fault_active, timer_error_flag;
  wire wg0 = waveform_generator_output[0];
  integer mismatches = 0, cmp_count = 0, seed = 89907, i, n, dt, pat;
  reg [31:0] rd_v, mdl [0:15];
  reg [1:0] resp;
  wvx_waveform_extension dut (.ref_clk(ref_clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .waveform_generator_output(waveform_generator_output),
    .update(update), .fault_events(fault_events),
    .debug_break(debug_break), .port_dir(port_dir), .pin_out(pin_out),
    .pin_override(pin_override), .dir_clear_mask(dir_clear_mask),
    .fault_active(fault_active), .timer_error_flag(timer_error_flag));
  wvx_tc_model tcm (.ref_clk(ref_clk), .srst(srst), .run(run), .kick(kick),
    .wave(waveform_generator_output), .upd(update));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task guard;
    if (n >= 200) begin
      mismatches = mismatches + 1;
      close_out;
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      if (!(lk && (a == 8'h00 || a == 8'h08 || a == 8'h28)) &&
          !(a == 8'h2C && fault_active))
        mdl[a[5:2]] = d;
      lk = lk | (a == 8'h30 && d[0]);
      @(posedge ref_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 200);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      guard;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge ref_clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 200);
      rd_v = {24'h0, s_axi_rdata[7:0]};
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      guard;
    end
  endtask
  initial begin
    for (i = 0; i < 16; i = i + 1)
      mdl[i] = 0;
    tick(3);
    srst <= 1'b0;
    run <= 1'b1;
    rd(8'h00);
    check("ctrl", rd_v, mdl[0]);
    rd(8'h3C);
    check("resp", resp, 2'h2);
    wr(8'h14, 32'h01);
    check("bresp", resp, 2'h2);
    dt = 4 + {$random(seed)} % 16;
    wr(8'h18, dt);
    check("bresp", resp, 2'h0);
    wr(8'h00, 32'h03);
    for (i = 0; i < 2; i = i + 1) begin
      for (n = 0; n < 200 && wg0 !== i[0]; n = n + 1)
        tick(1);
      guard;
      for (n = 0; n < 200 && wg0 === i[0]; n = n + 1)
        tick(1);
      guard;
      for (n = 0; n < 200 && pin_out[i] !== 1'b1; n = n + 1)
        tick(1);
      check("dead", n >= dt && n <= dt + 3, 1);
    end
    wr(8'h08, 32'h01);
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h0C, 32'h04 + i);
      fault_events <= 8'h01;
      tick(3);
      check("idle", fault_active, 0);
      fault_events <= 8'h00;
    end
    wr(8'h0C, 32'h17);
    debug_break <= 1'b1;
    fault_events <= $random(seed) & 32'hFE;
    tick(3);
    check("masked", fault_active, 0);
    debug_break <= 1'b0;
    fault_events <= 8'h00;
    wr(8'h0C, 32'h07);
    for (i = 0; i < 2; i = i + 1) begin
      fault_events <= {7'h0, i == 0};
      debug_break <= i == 1;
      tick(3);
      check("fault", fault_active, 1);
      tick(1);
      check("dirs", dir_clear_mask, 8'h0F);
      rd(8'h10);
      check("flag", rd_v[2], 1);
      fault_events <= 8'h00;
      debug_break <= 1'b0;
      wr(8'h10, 32'h04);
      for (n = 0; n < 200 && fault_active !== 1'b0; n = n + 1)
        tick(1);
      guard;
      tick(1);
      check("restore", dir_clear_mask, 0);
    end
    wr(8'h0C, 32'h03);
    fault_events <= 8'h01;
    tick(4);
    fault_events <= 8'h00;
    wr(8'h2C, 32'h55);
    tick(140);
    check("latched", fault_active, 1);
    wr(8'h10, 32'h00);
    rd(8'h10);
    check("flag", rd_v[2], 1);
    wr(8'h10, 32'h04);
    for (n = 0; n < 200 && fault_active !== 1'b0; n = n + 1)
      tick(1);
    guard;
    rd(8'h2C);
    check("portov", rd_v, mdl[11]);
    for (n = 0; n < 200 && wg0 !== 1'b1; n = n + 1)
      tick(1);
    guard;
    for (n = 0; n < 200 && wg0 === 1'b1; n = n + 1)
      tick(1);
    guard;
    run <= 1'b0;
    pat = {$random(seed)} % 256;
    wr(8'h00, 32'h20);
    wr(8'h24, pat);
    wr(8'h28, {$random(seed)} % 256);
    wr(8'h2C, {$random(seed)} % 256);
    tick(3);
    check("held", pin_out, dt);
    check("held_ov", pin_override, 8'h00);
    kick <= 1'b1;
    tick(1);
    kick <= 1'b0;
    tick(3);
    check("pattern", pin_out, pat);
    check("override", pin_override, mdl[10] & mdl[11]);
    run <= 1'b1;
    for (n = 0; n < 200 && wg0 !== 1'b1; n = n + 1)
      tick(1);
    guard;
    tick(3);
    check("cca", pin_out, 8'hFF);
    wr(8'h30, 32'h01);
    wr(8'h00, 32'h00);
    wr(8'h08, 32'hFF);
    rd(8'h00);
    check("ctrl", rd_v, mdl[0]);
    rd(8'h08);
    check("mask", rd_v, mdl[2]);
    close_out;
  end
endmodule // test_waveform_dead_time_fault_extension
